//--- include/aic_pkg.sv
/*
 Constants, codes and types for one serial transport-stream input channel.
 Assumes a single 250 MHz system clock shared by every user of the package.
*/
package aic_pkg;

    // Command group and item numbers
    localparam logic [7:0]  CAT_INPUT      = 8'h83;
    localparam logic [7:0]  SET_PKT_LEN    = 8'h01;
    localparam logic [7:0]  SET_PORT_NUM   = 8'h02;
    localparam logic [7:0]  SET_SIG_STATE  = 8'h03;
    localparam logic [7:0]  SET_RATE       = 8'h04;
    localparam logic [7:0]  SET_BYTE_CNT   = 8'h05;
    localparam logic [7:0]  SET_VIOL_CNT   = 8'h06;
    localparam logic [7:0]  SET_ENABLE     = 8'h08;
    localparam logic [7:0]  SET_POLARITY   = 8'h09;
    localparam logic [7:0]  SET_RATE_LIM   = 8'h0a;
    localparam logic [7:0]  SET_ACTIVE     = 8'h0b;
    localparam logic [7:0]  SET_SENSE_POL  = 8'h0c;
    localparam logic [7:0]  SET_SENSE_LEN  = 8'h0d;
    localparam logic [7:0]  SET_DROP_CNT   = 8'h0e;

    // Item codes
    localparam logic [7:0]  PKT_LEN_188    = 8'h00;
    localparam logic [7:0]  PKT_LEN_204    = 8'h01;
    localparam logic [7:0]  SIG_VALID      = 8'h00;
    localparam logic [7:0]  SIG_NO_CARRIER = 8'h01;
    localparam logic [7:0]  SIG_NO_LOCK    = 8'h02;
    localparam logic [7:0]  EN_OFF         = 8'h00;
    localparam logic [7:0]  EN_ON          = 8'h01;
    localparam logic [7:0]  EN_HOLD        = 8'h02;
    localparam logic [7:0]  POL_AUTO       = 8'h00;
    localparam logic [7:0]  POL_NORMAL     = 8'h01;
    localparam logic [7:0]  POL_INVERTED   = 8'h02;
    localparam logic [7:0]  SENSE_UNKNOWN  = 8'h00;
    localparam logic [7:0]  SENSE_FIRST    = 8'h01;
    localparam logic [7:0]  SENSE_SECOND   = 8'h02;
    localparam logic [7:0]  ST_INACTIVE    = 8'h00;
    localparam logic [7:0]  ST_ACTIVE      = 8'h01;

    // Reset values
    localparam logic [7:0]  PKT_LEN_RST    = 8'h00;
    localparam logic [7:0]  EN_RST         = 8'h00;
    localparam logic [7:0]  POL_RST        = 8'h00;
    localparam logic [7:0]  RATE_LIM_RST   = 8'h00;
    // Arbitrary identity defaults
    localparam logic [15:0] CHAN_INDEX_DEF = 16'h0000;
    localparam logic [7:0]  PORT_NUM_DEF   = 8'h00;

    // Packet lengths
    localparam logic [7:0]  TS_LEN_188     = 8'hbc;
    localparam logic [7:0]  TS_LEN_204     = 8'hcc;

    // Timing
    localparam int          CLK_PERIOD_NS  = 4;
    localparam int          RATE_WIN_NS    = 1000000000;
    localparam int          RATE_WIN_CYC   = RATE_WIN_NS / CLK_PERIOD_NS;
    // Bucket units: the limit in Mbit/s is added every cycle, a byte costs 8 bits per cycle-rate
    localparam logic [23:0] BYTE_COST      = 24'(8 * (1000 / CLK_PERIOD_NS));
    localparam logic [23:0] BUCKET_CAP     = 24'(2 * 204 * 8 * (1000 / CLK_PERIOD_NS));

    // Buffer
    localparam int          FIFO_WIDTH     = 9;
    localparam int          FIFO_DEPTH     = 8;

    typedef enum logic [2:0] {
        PK_IDLE = 3'b001,
        PK_PASS = 3'b010,
        PK_DROP = 3'b100
    } aic_pkt_st_t;

endpackage

//--- logic/aic_channel.sv
/*
 Settings, status, policer and forwarding path of one transport-stream input channel.
 Assumes the decoded byte stream, line status and management commands all run on clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module aic_channel #(
    parameter logic [15:0] CHAN_INDEX   = aic_pkg::CHAN_INDEX_DEF,
    parameter logic [7:0]  PORT_NUM     = aic_pkg::PORT_NUM_DEF,
    parameter int          RATE_WIN_CYC = aic_pkg::RATE_WIN_CYC
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // Management command
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_category,
    input  wire logic [7:0]  cmd_setting,
    input  wire logic [15:0] cmd_index,
    input  wire logic [63:0] cmd_wdata,
    // Management answer
    output logic             rsp_valid_q,
    output logic             rsp_error_q,
    output logic      [63:0] rsp_rdata_q,
    // Device-wide state
    input  wire logic        net_hold,
    input  wire logic        cap_exceeded,
    // Decoded input stream
    input  wire logic        ts_valid,
    output logic             ts_ready,
    input  wire logic [7:0]  ts_data,
    input  wire logic        ts_sop,
    input  wire logic        ts_code_err,
    input  wire logic        ts_carrier,
    input  wire logic        ts_lock,
    input  wire logic        ts_pol_known,
    input  wire logic        ts_pol_inverted,
    // Forwarded stream
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic      [7:0]  out_data,
    output logic             out_sop,
    // Active settings
    output logic             cfg_pkt204_q,
    output logic             rx_invert_q,
    output logic             chan_active_q,
    output logic             ipx_hold_q,
    output logic             applied_q
);

    function automatic logic in_range(input logic [63:0] v, input logic [7:0] top);
        in_range = (v[63:8] == 56'h0) && (v[7:0] <= top);
    endfunction

    function automatic logic [23:0] pkt_cost(input logic [7:0] len);
        pkt_cost = 24'(len) * aic_pkg::BYTE_COST;
    endfunction

    logic              cat_hit;
    logic              idx_hit;
    logic              wr_hit;
    logic              rd_ok;
    logic              wr_ok;
    logic [63:0]       rd_data;
    logic              commit;
    logic              acc;
    logic [7:0]        byte_idx;
    logic              fwd_ok;
    logic              lim_ok;
    logic              drop_inc;
    logic              fifo_push;
    logic              fifo_ready;
    logic [8:0]        fifo_out;
    logic [23:0]       bucket_add;
    logic [7:0]        cur_len;
    aic_pkg::aic_pkt_st_t pk_q;
    aic_pkg::aic_pkt_st_t pk_d;
    logic [7:0]        len_sh_q;
    logic [7:0]        pol_sh_q;
    logic [7:0]        lim_sh_q;
    logic [7:0]        len_q;
    logic [7:0]        pol_q;
    logic [7:0]        lim_q;
    logic [7:0]        en_q;
    logic [7:0]        pos_q;
    logic [7:0]        sense_len_q;
    logic [31:0]       win_q;
    logic [31:0]       win_bytes_q;
    logic [31:0]       rate_q;
    logic [23:0]       bucket_q;
    logic [63:0]       byte_cnt;
    logic [63:0]       viol_cnt;
    logic [63:0]       drop_cnt;
    logic [7:0]        sig_state;
    logic [7:0]        sense_pol;

    // Command decode
    assign cat_hit = cmd_valid && (cmd_category == aic_pkg::CAT_INPUT);
    assign idx_hit = cat_hit && (cmd_index == CHAN_INDEX);
    assign wr_hit  = idx_hit && cmd_write && wr_ok;

    always_comb begin
        wr_ok = 1'b0;
        case (cmd_setting)
            aic_pkg::SET_PKT_LEN:   wr_ok = in_range(cmd_wdata, aic_pkg::PKT_LEN_204);
            aic_pkg::SET_ENABLE:    wr_ok = in_range(cmd_wdata, aic_pkg::EN_HOLD);
            aic_pkg::SET_POLARITY:  wr_ok = in_range(cmd_wdata, aic_pkg::POL_INVERTED);
            aic_pkg::SET_RATE_LIM:  wr_ok = in_range(cmd_wdata, 8'hff);
            aic_pkg::SET_BYTE_CNT,
            aic_pkg::SET_VIOL_CNT,
            aic_pkg::SET_DROP_CNT:  wr_ok = 1'b1;
            default:                wr_ok = 1'b0;
        endcase
    end

    // Status decode
    always_comb begin
        if (!ts_carrier) begin
            sig_state = aic_pkg::SIG_NO_CARRIER;
        end else if (!ts_lock) begin
            sig_state = aic_pkg::SIG_NO_LOCK;
        end else begin
            sig_state = aic_pkg::SIG_VALID;
        end
        if (!ts_lock || !ts_pol_known) begin
            sense_pol = aic_pkg::SENSE_UNKNOWN;
        end else if (ts_pol_inverted) begin
            sense_pol = aic_pkg::SENSE_SECOND;
        end else begin
            sense_pol = aic_pkg::SENSE_FIRST;
        end
    end

    // Read mux
    always_comb begin
        rd_data = 64'h0;
        rd_ok   = 1'b1;
        case (cmd_setting)
            aic_pkg::SET_PKT_LEN:   rd_data = {56'h0, len_sh_q};
            aic_pkg::SET_PORT_NUM:  rd_data = {56'h0, PORT_NUM};
            aic_pkg::SET_SIG_STATE: rd_data = {56'h0, sig_state};
            aic_pkg::SET_RATE:      rd_data = {32'h0, rate_q};
            aic_pkg::SET_BYTE_CNT:  rd_data = byte_cnt;
            aic_pkg::SET_VIOL_CNT:  rd_data = viol_cnt;
            aic_pkg::SET_ENABLE:    rd_data = {56'h0, en_q};
            aic_pkg::SET_POLARITY:  rd_data = {56'h0, pol_sh_q};
            aic_pkg::SET_RATE_LIM:  rd_data = {56'h0, lim_sh_q};
            aic_pkg::SET_ACTIVE:    rd_data = chan_active_q ? {56'h0, aic_pkg::ST_ACTIVE}
                                                            : {56'h0, aic_pkg::ST_INACTIVE};
            aic_pkg::SET_SENSE_POL: rd_data = {56'h0, sense_pol};
            aic_pkg::SET_SENSE_LEN: rd_data = {56'h0, sense_len_q};
            aic_pkg::SET_DROP_CNT:  rd_data = drop_cnt;
            default:                rd_ok   = 1'b0;
        endcase
    end

    // Answer, one cycle after the command
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rsp_valid_q <= 1'b0;
            rsp_error_q <= 1'b0;
            rsp_rdata_q <= 64'h0;
        end else begin
            rsp_valid_q <= cat_hit;
            rsp_error_q <= cat_hit && (!idx_hit || (cmd_write ? !wr_ok : !rd_ok));
            rsp_rdata_q <= (idx_hit && !cmd_write && rd_ok) ? rd_data : 64'h0;
        end
    end

    // Written settings
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            len_sh_q <= aic_pkg::PKT_LEN_RST;
            pol_sh_q <= aic_pkg::POL_RST;
            lim_sh_q <= aic_pkg::RATE_LIM_RST;
            en_q     <= aic_pkg::EN_RST;
        end else if (wr_hit) begin
            case (cmd_setting)
                aic_pkg::SET_PKT_LEN:  len_sh_q <= cmd_wdata[7:0];
                aic_pkg::SET_POLARITY: pol_sh_q <= cmd_wdata[7:0];
                aic_pkg::SET_RATE_LIM: lim_sh_q <= cmd_wdata[7:0];
                aic_pkg::SET_ENABLE:   en_q     <= cmd_wdata[7:0];
                default:               en_q     <= en_q;
            endcase
        end
    end

    // Active settings follow the written ones whenever no hold stands
    assign commit = (en_q != aic_pkg::EN_HOLD) && !net_hold;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            len_q     <= aic_pkg::PKT_LEN_RST;
            pol_q     <= aic_pkg::POL_RST;
            lim_q     <= aic_pkg::RATE_LIM_RST;
            applied_q <= 1'b0;
        end else begin
            applied_q <= 1'b0;
            if (commit) begin
                len_q     <= len_sh_q;
                pol_q     <= pol_sh_q;
                lim_q     <= lim_sh_q;
                applied_q <= (len_q != len_sh_q) || (pol_q != pol_sh_q) || (lim_q != lim_sh_q);
            end
        end
    end

    // Outputs to the receiver, packetiser and IP transmit settings
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfg_pkt204_q  <= 1'b0;
            rx_invert_q   <= 1'b0;
            chan_active_q <= 1'b0;
            ipx_hold_q    <= 1'b0;
        end else begin
            cfg_pkt204_q  <= (len_q == aic_pkg::PKT_LEN_204);
            if (pol_q == aic_pkg::POL_AUTO) begin
                rx_invert_q <= ts_pol_known && ts_pol_inverted;
            end else begin
                rx_invert_q <= (pol_q == aic_pkg::POL_INVERTED);
            end
            chan_active_q <= (en_q != aic_pkg::EN_OFF) && !cap_exceeded;
            ipx_hold_q    <= (en_q == aic_pkg::EN_HOLD) || net_hold;
        end
    end

    // Byte position within a packet
    assign acc      = ts_valid && ts_ready;
    assign byte_idx = ts_sop ? 8'h00 : pos_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pos_q <= 8'h00;
        end else if (acc && (byte_idx != 8'hff)) begin
            pos_q <= byte_idx + 8'h01;
        end
    end

    // Packet length detection from the spacing of packet starts
    always_ff @(posedge clk_sys) begin
        if (srst || !ts_lock) begin
            sense_len_q <= aic_pkg::SENSE_UNKNOWN;
        end else if (acc && ts_sop && (pos_q != 8'h00)) begin
            if (pos_q == aic_pkg::TS_LEN_188) begin
                sense_len_q <= aic_pkg::SENSE_FIRST;
            end else if (pos_q == aic_pkg::TS_LEN_204) begin
                sense_len_q <= aic_pkg::SENSE_SECOND;
            end else begin
                sense_len_q <= aic_pkg::SENSE_UNKNOWN;
            end
        end
    end

    // Rate over a one-second window, counting only the first 188 bytes of each packet
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            win_q       <= 32'h0;
            win_bytes_q <= 32'h0;
            rate_q      <= 32'h0;
        end else if (win_q == 32'(RATE_WIN_CYC - 1)) begin
            win_q       <= 32'h0;
            win_bytes_q <= {31'h0, acc && (byte_idx < aic_pkg::TS_LEN_188)};
            rate_q      <= {win_bytes_q[28:0], 3'b000};
        end else begin
            win_q <= win_q + 32'h1;
            if (acc && (byte_idx < aic_pkg::TS_LEN_188)) begin
                win_bytes_q <= win_bytes_q + 32'h1;
            end
        end
    end

    // Token bucket; a limit of zero means no limit
    assign cur_len    = (sense_len_q == aic_pkg::SENSE_SECOND) ? aic_pkg::TS_LEN_204 : aic_pkg::TS_LEN_188;
    assign lim_ok     = (lim_q == 8'h00) || (bucket_q >= pkt_cost(cur_len));
    assign fwd_ok     = chan_active_q;
    assign bucket_add = bucket_q + {16'h0, lim_q};

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bucket_q <= 24'h0;
        end else if (acc && ts_sop && fwd_ok && lim_ok && (lim_q != 8'h00)) begin
            bucket_q <= bucket_q - pkt_cost(cur_len) + {16'h0, lim_q};
        end else if (bucket_add > aic_pkg::BUCKET_CAP) begin
            bucket_q <= aic_pkg::BUCKET_CAP;
        end else begin
            bucket_q <= bucket_add;
        end
    end

    // Per-packet pass or drop decision
    always_comb begin
        pk_d     = pk_q;
        drop_inc = 1'b0;
        if (acc && ts_sop) begin
            if (!fwd_ok) begin
                pk_d = aic_pkg::PK_DROP;
            end else if (lim_ok) begin
                pk_d = aic_pkg::PK_PASS;
            end else begin
                pk_d     = aic_pkg::PK_DROP;
                drop_inc = 1'b1;
            end
        end else if (!fwd_ok) begin
            pk_d = aic_pkg::PK_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pk_q <= aic_pkg::PK_IDLE;
        end else begin
            case (pk_d)
                aic_pkg::PK_IDLE: pk_q <= aic_pkg::PK_IDLE;
                aic_pkg::PK_PASS: pk_q <= aic_pkg::PK_PASS;
                aic_pkg::PK_DROP: pk_q <= aic_pkg::PK_DROP;
                default:          pk_q <= aic_pkg::PK_IDLE;
            endcase
        end
    end

    // Forward; in 188-byte mode the tail of a 204-byte packet is left out
    assign fifo_push = acc && (pk_d == aic_pkg::PK_PASS) && (cfg_pkt204_q || (byte_idx < aic_pkg::TS_LEN_188));
    assign ts_ready  = fifo_ready;

    aic_fifo #(
        .WIDTH (aic_pkg::FIFO_WIDTH),
        .DEPTH (aic_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .in_valid  (fifo_push),
        .in_ready  (fifo_ready),
        .in_data   ({ts_sop, ts_data}),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (fifo_out)
    );

    assign out_sop  = fifo_out[8];
    assign out_data = fifo_out[7:0];

    // Counters, each cleared by any write to its own setting
    aic_cnt64 u_byte_cnt (
        .clk_sys (clk_sys),
        .srst    (srst),
        .clr     (wr_hit && (cmd_setting == aic_pkg::SET_BYTE_CNT)),
        .inc     (acc),
        .count_q (byte_cnt)
    );

    aic_cnt64 u_viol_cnt (
        .clk_sys (clk_sys),
        .srst    (srst),
        .clr     (wr_hit && (cmd_setting == aic_pkg::SET_VIOL_CNT)),
        .inc     (ts_code_err),
        .count_q (viol_cnt)
    );

    aic_cnt64 u_drop_cnt (
        .clk_sys (clk_sys),
        .srst    (srst),
        .clr     (wr_hit && (cmd_setting == aic_pkg::SET_DROP_CNT)),
        .inc     (drop_inc),
        .count_q (drop_cnt)
    );

endmodule
`default_nettype wire

//--- logic/aic_cnt64.sv
/*
 Clearable 64-bit event counter.
 Assumes clear and increment arrive on clk_sys from the same clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module aic_cnt64 (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // Control
    input  wire logic        clr,
    input  wire logic        inc,
    // Count
    output logic      [63:0] count_q
);
    // An event in the clearing cycle is kept
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            count_q <= 64'h0;
        end else if (clr) begin
            count_q <= {63'h0, inc};
        end else if (inc) begin
            count_q <= count_q + 64'h1;
        end
    end
endmodule
`default_nettype wire

//--- logic/aic_fifo.sv
/*
 Flip-flop FIFO with valid and ready on both sides.
 Assumes one clock; depth is a power of two.
*/
`timescale 1ns/1ns
`default_nettype none
module aic_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             srst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

//--- testbench/aic_channel_asserts.sv
/* Checker for the aic_channel ports.
   Assumes clk_sys and synchronous srst of the top module. */
`timescale 1ns/1ns
`default_nettype none
module aic_chk (
    // Clock and reset
    input wire logic        clk_sys, srst,
    // Management
    input wire logic        cmd_valid, cmd_write, rsp_valid_q, rsp_error_q,
    input wire logic [7:0]  cmd_category, cmd_setting,
    input wire logic [15:0] cmd_index,
    input wire logic [63:0] cmd_wdata, rsp_rdata_q,
    // State
    input wire logic        net_hold, cap_exceeded, cfg_pkt204_q, chan_active_q, ipx_hold_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    wire logic hit = cmd_valid && cmd_category == 8'h83;
    wire logic wr  = hit && cmd_write && cmd_index == 16'h0000;
    answer_given_a: assert property (hit |=> rsp_valid_q) else $error("no answer");
    answer_silent_a: assert property (!hit |=> !rsp_valid_q) else $error("stray answer");
    index_error_a: assert property (hit && cmd_index != 16'h0000 |=> rsp_error_q) else $error("index");
    len_range_a: assert property (wr && cmd_setting == 8'h01 && cmd_wdata > 64'h1 |=> rsp_error_q)
        else $error("length range");
    rate_readonly_a: assert property (wr && cmd_setting == 8'h04 |=> rsp_error_q) else $error("rate ro");
    enable_range_a: assert property (wr && cmd_setting == 8'h08 && cmd_wdata > 64'h2 |=> rsp_error_q)
        else $error("enable range");
    enable_on_a: assert property (wr && cmd_setting == 8'h08 && cmd_wdata == 64'h1 && !net_hold
        && !cap_exceeded ##1 !cap_exceeded |=> chan_active_q) else $error("not active");
    cap_off_a: assert property (cap_exceeded [*2] |-> !chan_active_q) else $error("over cap");
    hold_freeze_a: assert property (ipx_hold_q |-> $stable(cfg_pkt204_q)) else $error("held change");
    c_on: cover property (chan_active_q);
    c_hold: cover property (ipx_hold_q);
    c_err: cover property (rsp_valid_q && rsp_error_q);
endmodule
bind aic_channel aic_chk i_aic_chk (.*);
`default_nettype wire

//--- testbench/aic_host.sv
/* Host controller model issuing indexed management commands.
   Assumes the answer comes one edge after the command is taken. */
`timescale 1ns/1ns
`default_nettype none
module aic_host (
    // Clock and answer
    input wire logic        clk_sys, rsp_valid_q, rsp_error_q,
    input wire logic [63:0] rsp_rdata_q,
    // Command
    output logic            cmd_valid, cmd_write,
    output logic [7:0]      cmd_category, cmd_setting,
    output logic [15:0]     cmd_index,
    output logic [63:0]     cmd_wdata
);
    initial {cmd_valid, cmd_write, cmd_category, cmd_setting, cmd_index, cmd_wdata} = '0;
    task automatic xfer(input logic w, input logic [7:0] c, s, input logic [15:0] i,
                        input logic [63:0] d, output logic v, e, output logic [63:0] r);
        @(posedge clk_sys);
        #1;
        {cmd_valid, cmd_write, cmd_category, cmd_setting, cmd_index, cmd_wdata} = {1'b1, w, c, s, i, d};
        @(posedge clk_sys);
        #1;
        v = rsp_valid_q;
        e = rsp_error_q;
        r = rsp_rdata_q;
        cmd_valid = 1'b0;
        cmd_wdata = ~d;
    endtask
endmodule
`default_nettype wire

//--- testbench/tb_aic_channel.sv
/* Self-checking bench for aic_channel.
   Assumes aic_host drives commands; the bench drives the stream. */
`timescale 1ns/1ns
`default_nettype none
module tb_aic_channel;
    logic clk_sys = 0, srst = 1, net_hold = 0, cap_exceeded = 0, ts_valid = 0, ts_sop = 0, ts_code_err = 0;
    logic ts_carrier = 1, ts_lock = 1, ts_pol_known = 0, ts_pol_inverted = 0, out_ready = 0;
    logic cmd_valid, cmd_write, rsp_valid_q, rsp_error_q, ts_ready, out_valid, out_sop;
    logic cfg_pkt204_q, rx_invert_q, chan_active_q, ipx_hold_q, applied_q, v, e;
    logic [7:0]  ts_data = 0, out_data, cmd_category, cmd_setting;
    logic [15:0] cmd_index;
    logic [63:0] cmd_wdata, rsp_rdata_q, r;
    int err_total = 0, cmp_count = 0;
    always #2 clk_sys = ~clk_sys;
    aic_channel #(.RATE_WIN_CYC(100)) i_aic_channel (.*);
    aic_host i_aic_host (.*);
    task automatic end_sim;
        $display("compares %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [65:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic rd(input logic [7:0] s, input logic [63:0] x);
        i_aic_host.xfer(1'b0, 8'h83, s, 16'h0000, 64'h0, v, e, r);
        chk("read", {v, e, r}, {2'b10, x});
    endtask
    task automatic wr(input logic [7:0] s, input logic [63:0] d, input logic x);
        i_aic_host.xfer(1'b1, 8'h83, s, 16'h0000, d, v, e, r);
        chk("write", {v, e, r}, {1'b1, x, 64'h0});
    endtask
    task automatic put(input logic [7:0] d, input logic s);
        int n;
        n = 0;
        ts_valid = 1'b1;
        ts_data = d;
        ts_sop = s;
        while (!ts_ready && n < 20) begin tick(1); n++; end
        if (!ts_ready) begin err_total++; end_sim; end
        tick(1);
    endtask
    task automatic t_regs;
        rd(8'h01, 64'h0);
        rd(8'h08, 64'h0);
        rd(8'h09, 64'h0);
        rd(8'h02, 64'(aic_pkg::PORT_NUM_DEF));
        wr(8'h0a, 64'h5, 1'b0);
        rd(8'h0a, 64'h5);
        wr(8'h0a, 64'h0, 1'b0);
        wr(8'h01, 64'h2, 1'b1);
        wr(8'h08, 64'h3, 1'b1);
        wr(8'h09, 64'h3, 1'b1);
        wr(8'h04, 64'h1, 1'b1);
        wr(8'h0b, 64'h1, 1'b1);
        i_aic_host.xfer(1'b0, 8'h83, 8'h01, 16'h0001, 64'h0, v, e, r);
        chk("index", {v, e, r}, {2'b11, 64'h0});
        i_aic_host.xfer(1'b0, 8'h82, 8'h01, 16'h0000, 64'h0, v, e, r);
        chk("category", {65'h0, v}, 66'h0);
        rd(8'h03, 64'h0);
        ts_carrier = 1'b0;
        rd(8'h03, 64'h1);
        ts_carrier = 1'b1;
        ts_lock = 1'b0;
        rd(8'h03, 64'h2);
        ts_lock = 1'b1;
        ts_pol_known = 1'b1;
        ts_pol_inverted = 1'b1;
        rd(8'h0c, 64'h2);
        chk("auto invert", {65'h0, rx_invert_q}, 66'h1);
        ts_pol_inverted = 1'b0;
        rd(8'h0c, 64'h1);
    endtask
    task automatic t_stream;
        wr(8'h08, 64'h1, 1'b0);
        tick(2);
        for (int i = 0; i < 8; i++) put(8'(i), i == 0);
        ts_valid = 1'b0;
        chk("full", {65'h0, ts_ready}, 66'h0);
        out_ready = 1'b1;
        for (int i = 0; i < 8; i++) begin
            chk("out", {56'h0, out_valid, out_sop, out_data}, {56'h0, 1'b1, i == 0, 8'(i)});
            tick(1);
        end
        out_ready = 1'b0;
        chk("empty", {65'h0, out_valid}, 66'h0);
        rd(8'h05, 64'h8);
        wr(8'h05, 64'h1234, 1'b0);
        rd(8'h05, 64'h0);
        ts_code_err = 1'b1;
        tick(3);
        ts_code_err = 1'b0;
        rd(8'h06, 64'h3);
        wr(8'h06, 64'h0, 1'b0);
        rd(8'h06, 64'h0);
    endtask
    task automatic t_gate;
        cap_exceeded = 1'b1;
        tick(2);
        rd(8'h0b, 64'h0);
        cap_exceeded = 1'b0;
        tick(2);
        rd(8'h0b, 64'h1);
        wr(8'h08, 64'h0, 1'b0);
        rd(8'h0b, 64'h0);
        put(8'h55, 1'b1);
        ts_valid = 1'b0;
        tick(3);
        chk("off", {65'h0, out_valid}, 66'h0);
    endtask
    task automatic t_hold;
        wr(8'h08, 64'h2, 1'b0);
        wr(8'h01, 64'h1, 1'b0);
        wr(8'h09, 64'h2, 1'b0);
        rd(8'h01, 64'h1);
        chk("held", {64'h0, ipx_hold_q, cfg_pkt204_q}, 66'h2);
        net_hold = 1'b1;
        wr(8'h08, 64'h1, 1'b0);
        tick(2);
        chk("net held", {65'h0, cfg_pkt204_q}, 66'h0);
        net_hold = 1'b0;
        tick(1);
        chk("applied pulse", {65'h0, applied_q}, 66'h1);
        tick(1);
        chk("applied", {63'h0, ipx_hold_q, cfg_pkt204_q, rx_invert_q}, 66'h3);
    endtask
    task automatic t_drop;
        wr(8'h0a, 64'hff, 1'b0);
        tick(1);
        for (int i = 0; i < 378; i++) put(8'(i), (i % 188) == 0);
        rd(8'h04, 64'h320);
        rd(8'h0d, 64'h1);
        rd(8'h0e, 64'h3);
        ts_valid = 1'b0;
        wr(8'h0e, 64'h7, 1'b0);
        rd(8'h0e, 64'h0);
    endtask
    initial begin
        tick(3);
        srst = 1'b0;
        t_regs;
        t_stream;
        t_gate;
        t_hold;
        t_drop;
        end_sim;
    end
endmodule
`default_nettype wire
